// [rtl/dmr_requester.sv]
`timescale 1ns/1ps
module dmr_requester
  import dmr_pkg::*;
#(
  parameter int SETTLE_CYCLES = GRANT_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic data_request,
  input wire logic transfer_release,
  input wire logic second_bus_selected,
  input wire logic acknowledge_clear_enable,
  input wire logic transfer_start_clear,
  input wire logic controller_clear,
  input wire dmr_pkg::dmr_bus_in_t bus_a_in,
  input wire dmr_pkg::dmr_bus_in_t bus_b_in,
  output dmr_pkg::dmr_bus_out_t bus_a_out,
  output dmr_pkg::dmr_bus_out_t bus_b_out,
  output logic dma_mastership_active
);
  import dmr_pkg::*;

  // ************************************************************
  // Shared state
  // ************************************************************
  // Index 0 is bus A, index 1 is bus B
  localparam int N_BUS = 2;

  logic ack;
  logic busy;
  logic master_q;
  logic [SETTLE_W-1:0] settle;
  logic [N_BUS-1:0] grant_in;
  logic [N_BUS-1:0] busy_in;
  logic [N_BUS-1:0] sync_in;
  logic [N_BUS-1:0] grant_q;
  logic [N_BUS-1:0] pass;
  logic [N_BUS-1:0] pass_set;
  logic [N_BUS-1:0] bus_sel;
  dmr_bus_out_t next_out [N_BUS];
  dmr_bus_out_t out_q [N_BUS];

  // ************************************************************
  // Qualification
  // ************************************************************
  wire clear_all = controller_clear | transfer_start_clear;
  wire hold = rst | (clock_enable & clear_all);
  wire request_qual = data_request & ~transfer_release;
  wire requesting = request_qual & ~ack & ~busy;

  // ************************************************************
  // Line taps
  // ************************************************************
  assign grant_in[0] = bus_a_in.dma_grant_line;
  assign grant_in[1] = bus_b_in.dma_grant_line;
  assign busy_in[0] = bus_a_in.bus_busy_line;
  assign busy_in[1] = bus_b_in.bus_busy_line;
  assign sync_in[0] = bus_a_in.slave_sync_line;
  assign sync_in[1] = bus_b_in.slave_sync_line;
  assign bus_sel[0] = ~second_bus_selected;
  assign bus_sel[1] = second_bus_selected;

  // ************************************************************
  // Selector onto the chosen bus lines
  // ************************************************************
  wire sel_idx = second_bus_selected;
  wire sel_grant = grant_in[sel_idx];
  wire sel_busy = busy_in[sel_idx];
  wire sel_sync = sync_in[sel_idx];
  wire sel_pass = pass[sel_idx];
  wire sel_grant_rise = sel_grant & ~grant_q[sel_idx];
  wire settle_done = (settle == SETTLE_W'(SETTLE_CYCLES));
  wire settle_run = (settle != '0) & ~settle_done;
  // Settle count stands in for the delay, so the pass flop decides first
  wire ack_set = settle_done & sel_grant & ~sel_pass & ~ack;
  wire busy_set = ack & ~busy & ~sel_grant & ~sel_busy & ~sel_sync;
  wire ack_clr = acknowledge_clear_enable & busy;
  wire next_master = busy & ~transfer_release;

  // ************************************************************
  // Per-bus grant pass-through and line drivers
  // ************************************************************
  for (genvar b = 0; b < N_BUS; b++) begin : g_bus
    // Grant passes when the bus is not ours or nothing is wanted
    assign pass_set[b] = grant_in[b] & ~grant_q[b] & (~bus_sel[b] | ~requesting);
    assign next_out[b].dma_request_line = requesting & bus_sel[b];
    assign next_out[b].selection_acknowledge = ack & bus_sel[b];
    assign next_out[b].bus_busy_line = busy & bus_sel[b];
    assign next_out[b].dma_grant_out = pass[b];

    always_ff @(posedge clock) begin
      if (hold) begin
        grant_q[b] <= 1'b0;
        pass[b] <= 1'b0;
        out_q[b] <= BUS_OUT_RESET;
      end else if (clock_enable) begin
        grant_q[b] <= grant_in[b];
        out_q[b] <= next_out[b];
        // Removed grant always wins, so pass clears on the first enabled edge after the grant drops
        if (!grant_in[b]) begin
          pass[b] <= 1'b0;
        end else if (pass_set[b]) begin
          pass[b] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Grant settle counter
  // ************************************************************
  always_ff @(posedge clock) begin
    if (hold) begin
      settle <= '0;
    end else if (clock_enable) begin
      if (!sel_grant) begin
        settle <= '0;
      end else if (sel_grant_rise) begin
        settle <= SETTLE_W'(1);
      end else if (settle_run) begin
        settle <= settle + SETTLE_W'(1);
      end
    end
  end

  // ************************************************************
  // Acknowledge flip-flop
  // ************************************************************
  // Set beats clear; both cannot meet while busy is still low
  always_ff @(posedge clock) begin
    if (hold) begin
      ack <= 1'b0;
    end else if (clock_enable) begin
      if (ack_set) begin
        ack <= 1'b1;
      end else if (ack_clr) begin
        ack <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Bus busy flip-flop
  // ************************************************************
  // Release beats a fresh set; with acknowledge_clear_enable low, ack stays set and busy sets again once release drops
  always_ff @(posedge clock) begin
    if (hold) begin
      busy <= 1'b0;
    end else if (clock_enable) begin
      if (transfer_release) begin
        busy <= 1'b0;
      end else if (busy_set) begin
        busy <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Mastership indication
  // ************************************************************
  always_ff @(posedge clock) begin
    if (hold) begin
      master_q <= 1'b0;
    end else if (clock_enable) begin
      master_q <= next_master;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus_a_out = out_q[0];
  assign bus_b_out = out_q[1];
  assign dma_mastership_active = master_q;

endmodule : dmr_requester

// [rtl/dmr_pkg.sv]
package dmr_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int GRANT_SETTLE_NS = 100;
  // Least time, rounded up, never below one cycle
  localparam int GRANT_SETTLE_CYCLES_RAW =
      (GRANT_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int GRANT_SETTLE_CYCLES =
      (GRANT_SETTLE_CYCLES_RAW < 1) ? 1 : GRANT_SETTLE_CYCLES_RAW;
  localparam int SETTLE_W = 4;

  // ************************************************************
  // Per-bus line groups
  // ************************************************************
  typedef struct packed {
    logic dma_grant_line;
    logic bus_busy_line;
    logic slave_sync_line;
  } dmr_bus_in_t;

  typedef struct packed {
    logic dma_request_line;
    logic selection_acknowledge;
    logic bus_busy_line;
    logic dma_grant_out;
  } dmr_bus_out_t;

  localparam dmr_bus_out_t BUS_OUT_RESET = '0;

  // ************************************************************
  // Requester states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_ACK = 2'b11,
    ST_MASTER = 2'b10
  } dmr_state_t;

endpackage : dmr_pkg

// [verif/dmr_arbiter_model.sv]
`timescale 1ns/1ps
module dmr_arbiter_model import dmr_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic offer,
  input wire dmr_pkg::dmr_bus_out_t bus_out,
  output dmr_pkg::dmr_bus_in_t bus_in
);
  // Old master keeps busy and sync up after the grant, so the requester must wait
  always_ff @(posedge clock) begin
    bus_in.dma_grant_line <= !rst && (offer || bus_out.dma_request_line)
        && !bus_out.selection_acknowledge;
    bus_in.bus_busy_line <= !rst && bus_in.dma_grant_line;
    bus_in.slave_sync_line <= !rst && bus_in.bus_busy_line;
  end
endmodule : dmr_arbiter_model

// [verif/dmr_requester_checker.sv]
`timescale 1ns/1ps
module dmr_requester_checker import dmr_pkg::*; #(
  parameter int SETTLE_CYCLES = GRANT_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic transfer_release,
  input wire logic controller_clear,
  input wire logic transfer_start_clear,
  input wire dmr_pkg::dmr_bus_in_t bus_a_in,
  input wire dmr_pkg::dmr_bus_out_t bus_a_out,
  input wire dmr_pkg::dmr_bus_out_t bus_b_out,
  input wire logic dma_mastership_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_one; !(bus_a_out.dma_request_line && bus_b_out.dma_request_line); endproperty
  a_one: assert property (p_one) else $error("two requests");
  property p_absorb; bus_a_out.dma_request_line |-> !bus_a_out.dma_grant_out; endproperty
  a_absorb: assert property (p_absorb) else $error("grant passed");
  property p_settle;
    $rose(bus_a_out.selection_acknowledge) |-> $past(bus_a_in.dma_grant_line, SETTLE_CYCLES);
  endproperty
  a_settle: assert property (p_settle) else $error("early ack");
  property p_ack; bus_a_out.selection_acknowledge |-> !bus_a_out.dma_request_line; endproperty
  a_ack: assert property (p_ack) else $error("request with ack");
  property p_busy; $rose(bus_a_out.bus_busy_line) |-> $past(bus_a_in) == 3'h0; endproperty
  a_busy: assert property (p_busy) else $error("busy too soon");
  property p_master; dma_mastership_active |-> (bus_a_out.bus_busy_line ||
      bus_b_out.bus_busy_line) && !bus_a_out.dma_request_line; endproperty
  a_master: assert property (p_master) else $error("bad master");
  property p_rel; transfer_release |-> ##[1:2] !dma_mastership_active; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_clr; controller_clear || transfer_start_clear |-> ##2
      !bus_a_out.selection_acknowledge && !dma_mastership_active; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
endmodule : dmr_requester_checker
bind dmr_requester dmr_requester_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.clock, .rst,
  .transfer_release, .controller_clear, .transfer_start_clear, .bus_a_in, .bus_a_out,
  .bus_b_out, .dma_mastership_active);

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import dmr_pkg::*;
  logic clock = 1'b0, rst = 1'b1, data_request = 1'b0, transfer_release = 1'b0;
  logic second_bus_selected = 1'b0, acknowledge_clear_enable = 1'b0, controller_clear = 1'b0;
  logic transfer_start_clear = 1'b0, offer_a = 1'b0, offer_b = 1'b0, dma_mastership_active;
  dmr_bus_in_t bus_a_in, bus_b_in;
  dmr_bus_out_t bus_a_out, bus_b_out;
  int n_fail = 0, check_count = 0;
  dmr_requester i_dmr_requester (.clock, .rst, .clock_enable(1'b1), .data_request,
    .transfer_release, .second_bus_selected, .acknowledge_clear_enable, .transfer_start_clear,
    .controller_clear, .bus_a_in, .bus_b_in, .bus_a_out, .bus_b_out, .dma_mastership_active);
  dmr_arbiter_model i_dmr_arbiter_model_a (.clock, .rst, .offer(offer_a), .bus_out(bus_a_out),
    .bus_in(bus_a_in));
  dmr_arbiter_model i_dmr_arbiter_model_b (.clock, .rst, .offer(offer_b), .bus_out(bus_b_out),
    .bus_in(bus_b_in));
  initial begin
    forever #5 clock = !clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic t_master(input logic sel);
    second_bus_selected = sel;
    data_request = 1'b1;
    for (int i = 0; i < 60 && dma_mastership_active !== 1'b1; i++) cyc(1);
    chk(dma_mastership_active, 1'b1);
    chk(sel ? bus_b_out.bus_busy_line : bus_a_out.bus_busy_line, 1'b1);
    chk(sel ? bus_a_out.dma_request_line : bus_b_out.dma_request_line, 1'b0);
    cyc(3);
    chk(sel ? bus_b_out.selection_acknowledge : bus_a_out.selection_acknowledge, 1'b0);
    transfer_release = 1'b1;
    data_request = 1'b0;
    cyc(1);
    transfer_release = 1'b0;
    cyc(2);
    chk(dma_mastership_active, 1'b0);
  endtask : t_master
  task automatic t_pass;
    // Idle requester forwards both grants, its own bus included
    {offer_a, offer_b} = 2'b11;
    cyc(4);
    chk(bus_a_out.dma_grant_out, 1'b1);
    chk(bus_b_out.dma_grant_out, 1'b1);
    {offer_a, offer_b} = 2'b00;
    cyc(4);
    chk(bus_a_out.dma_grant_out, 1'b0);
    chk(bus_b_out.dma_grant_out, 1'b0);
  endtask : t_pass
  task automatic t_clear;
    second_bus_selected = 1'b0;
    data_request = 1'b1;
    cyc(13);
    chk(bus_a_out.selection_acknowledge, 1'b0);
    cyc(1);
    chk(bus_a_out.selection_acknowledge, 1'b1);
    transfer_start_clear = 1'b1;
    cyc(1);
    transfer_start_clear = 1'b0;
    cyc(1);
    chk(bus_a_out.selection_acknowledge, 1'b0);
    cyc(13);
    chk(bus_a_out.selection_acknowledge, 1'b1);
    controller_clear = 1'b1;
    data_request = 1'b0;
    cyc(2);
    controller_clear = 1'b0;
    chk(bus_a_out.dma_request_line, 1'b0);
    chk(bus_a_out.selection_acknowledge, 1'b0);
  endtask : t_clear
  initial begin
    cyc(8);
    rst = 1'b0;
    acknowledge_clear_enable = 1'b1;
    t_master(1'b0);
    t_master(1'b1);
    t_pass;
    t_clear;
    tally_and_finish;
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
endmodule : tb
